// ==== src/rpd_defines.svh ====
`ifndef RPD_DEFINES_SVH
`define RPD_DEFINES_SVH

`define RPD_MCLK_KHZ 50000
`define RPD_TICK_KHZ 4
`define RPD_TICK_DIV (`RPD_MCLK_KHZ / `RPD_TICK_KHZ)
`define RPD_MS2TK(ms) ((ms) * `RPD_TICK_KHZ)
`define RPD_SCAN_TICKS 4
`define RPD_MS2SCAN(ms) ((ms) * `RPD_TICK_KHZ / `RPD_SCAN_TICKS)

`define RPD_PERIOD10_MS 100
`define RPD_PERIOD20_MS 50
`define RPD_BRK60_PCT 60
`define RPD_BRK66_PCT 66
`define RPD_PCT_FULL 100
`define RPD_FAST_DIV 100
`define RPD_FAST_DUTY_DIV 2
`define RPD_PDP10_MS 900
`define RPD_PDP20_MS 450
`define RPD_IDT10_MS 900
`define RPD_IDT20_MS 450
`define RPD_MUTE_TAIL_MS 5
`define RPD_DEB_MS 10
`define RPD_VALID_MS 40
`define RPD_ROLL_MS 5
`define RPD_ONHOOK_MS 300

`define RPD_HZ_PER_KHZ 1000
`define RPD_TONE10_HZ 1000
`define RPD_TONE20_HZ 2000
`define RPD_TONE_EDGES 2

`define RPD_ROWS 4
`define RPD_COLS 3
`define RPD_MEM_DEPTH 17
`define RPD_KEY_STAR 4'h9
`define RPD_KEY_ZERO 4'ha
`define RPD_KEY_HASH 4'hb
`define RPD_ZERO_PULSES 4'ha
`define RPD_TMR_W 12
`define RPD_DIV_W 14

`endif

// ==== src/rpd_pkg.sv ====
package rpd_pkg;
	typedef enum logic [2:0] {
		RPD_IDLE,
		RPD_PAUSE,
		RPD_BREAK,
		RPD_MAKE,
		RPD_TAIL
	} rpd_state_t;
	typedef logic [3:0] rpd_digit_t;
	typedef logic [4:0] rpd_count_t;
	typedef logic [11:0] rpd_tmr_t;
endpackage : rpd_pkg

// ==== src/rpd_key_if.sv ====
`timescale 1ns/1ns
interface rpd_key_if;
	import rpd_pkg::*;
	logic tick;
	logic on_hook;
	logic sensed;
	logic busy;
	logic held;
	logic accept;
	rpd_digit_t code;
	modport scan (input tick, on_hook,
		output sensed, busy, held, accept, code);
	modport ctrl (output tick, on_hook,
		input sensed, busy, held, accept, code);
endinterface : rpd_key_if

// ==== src/rpd_keyscan.sv ====
`timescale 1ns/1ns
`include "rpd_defines.svh"
module rpd_keyscan (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] row_i,
	output logic [3:0] row_o,
	output logic [3:0] row_oe,
	input wire logic [2:0] col_i,
	output logic [2:0] col_o,
	output logic [2:0] col_oe,
	rpd_key_if.scan kif
);
	import rpd_pkg::*;
	localparam logic [5:0] DEB_N = 6'(`RPD_MS2SCAN(`RPD_DEB_MS));
	localparam logic [5:0] VALID_N = 6'(`RPD_MS2SCAN(`RPD_VALID_MS));
	localparam logic [5:0] ROLL_N = 6'(`RPD_MS2SCAN(`RPD_ROLL_MS));
	logic [1:0] phase_q;
	logic scan_q;
	logic [3:0] row_snap_q;
	rpd_digit_t cand_q;
	logic [5:0] cnt_q;
	logic done_q;
	logic roll_q;
	logic held_q;
	logic acc_q;
	logic eval, valid, none, sensed;
	logic [1:0] ridx, cidx;
	logic [5:0] cnt_nx, need;
	rpd_digit_t code;

	// Between scans: columns held low, rows watched without any clock
	always_comb begin
		row_o = 4'h0;
		row_oe = 4'h0;
		col_o = 3'h0;
		col_oe = 3'h0;
		if (kif.on_hook) begin
			row_o = 4'hf;
			row_oe = 4'hf;
			col_o = 3'h7;
			col_oe = 3'h7;
		end else if (!scan_q) begin
			col_oe = 3'h7;
		end else begin
			case (phase_q)
				2'h0: begin
					col_o = 3'h7;
					col_oe = 3'h7;
				end
				2'h1: col_oe = 3'h7;
				2'h2: begin
					row_o = 4'hf;
					row_oe = 4'hf;
				end
				default: row_oe = 4'hf;
			endcase
		end
	end

	always_comb begin
		ridx = 2'h0;
		cidx = 2'h0;
		for (int i = 0; i < `RPD_ROWS; i++) begin
			if (!row_snap_q[i]) ridx = 2'(i);
		end
		for (int j = 0; j < `RPD_COLS; j++) begin
			if (!col_i[j]) cidx = 2'(j);
		end
	end

	assign sensed = !kif.on_hook && !scan_q && (row_i != 4'hf);
	assign eval = scan_q && kif.tick && (phase_q == 2'h3);
	assign valid = $onehot(~row_snap_q) && $onehot(~col_i);
	assign none = (&row_snap_q) && (&col_i);
	assign code = rpd_digit_t'({2'h0, ridx} * 4'(`RPD_COLS) + {2'h0, cidx});
	assign need = roll_q ? ROLL_N : VALID_N;
	always_comb begin
		cnt_nx = 6'h1;
		if (code == cand_q && cnt_q != 6'h0) begin
			cnt_nx = (&cnt_q) ? cnt_q : cnt_q + 6'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_q <= 1'b0;
			phase_q <= 2'h0;
			row_snap_q <= 4'hf;
		end else if (kif.on_hook) begin
			scan_q <= 1'b0;
			phase_q <= 2'h0;
			row_snap_q <= 4'hf;
		end else begin
			if (sensed) scan_q <= 1'b1;
			if (eval && none) scan_q <= 1'b0;
			if (scan_q && kif.tick) phase_q <= phase_q + 2'h1;
			if (scan_q && kif.tick && phase_q == 2'h1) row_snap_q <= row_i;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cand_q <= 4'h0;
			cnt_q <= 6'h0;
			done_q <= 1'b0;
			roll_q <= 1'b0;
			held_q <= 1'b0;
			acc_q <= 1'b0;
		end else if (kif.on_hook) begin
			cnt_q <= 6'h0;
			done_q <= 1'b0;
			roll_q <= 1'b0;
			held_q <= 1'b0;
			acc_q <= 1'b0;
		end else begin
			acc_q <= 1'b0;
			if (eval) begin
				if (none) begin
					cnt_q <= 6'h0;
					done_q <= 1'b0;
					roll_q <= 1'b0;
					held_q <= 1'b0;
				end else if (!valid) begin
					cnt_q <= 6'h0;
					held_q <= 1'b0;
				end else begin
					cand_q <= code;
					cnt_q <= cnt_nx;
					held_q <= cnt_nx >= DEB_N;
					if (code != cand_q) done_q <= 1'b0;
					if ((!done_q || code != cand_q) && cnt_nx >= need) begin
						acc_q <= 1'b1;
						done_q <= 1'b1;
						roll_q <= 1'b1;
					end
				end
			end
		end
	end

	assign kif.sensed = sensed;
	assign kif.busy = scan_q;
	assign kif.held = held_q;
	assign kif.accept = acc_q;
	assign kif.code = cand_q;
endmodule : rpd_keyscan

// ==== src/rpd_dialer.sv ====
`timescale 1ns/1ns
`include "rpd_defines.svh"
module rpd_dialer #(
	parameter int unsigned TICK_DIV = `RPD_TICK_DIV
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic HOOK_TEST_SELECT,
	input wire logic DIAL_RATE_SELECT,
	input wire logic BREAK_RATIO_SELECT,
	input wire logic [3:0] ROW_I,
	output logic [3:0] ROW_O,
	output logic [3:0] ROW_OE,
	input wire logic [2:0] COL_I,
	output logic [2:0] COL_O,
	output logic [2:0] COL_OE,
	output logic PULSE_OUT_N_O,
	output logic PULSE_OUT_N_OE,
	output logic MUTE_OUT_N_O,
	output logic MUTE_OUT_N_OE,
	output logic TONE_FEEDBACK_OUT,
	output logic CLOCK_RUN,
	output rpd_pkg::rpd_count_t STORED_DIGITS
);
	import rpd_pkg::*;

	// Tick counts at the nominal 4 kHz rate
	localparam rpd_tmr_t PER10_TK = 12'(`RPD_MS2TK(`RPD_PERIOD10_MS));
	localparam rpd_tmr_t PER20_TK = 12'(`RPD_MS2TK(`RPD_PERIOD20_MS));
	localparam rpd_tmr_t B10_60_TK = 12'(`RPD_MS2TK(`RPD_PERIOD10_MS)
		* `RPD_BRK60_PCT / `RPD_PCT_FULL);
	localparam rpd_tmr_t B10_66_TK = 12'(`RPD_MS2TK(`RPD_PERIOD10_MS)
		* `RPD_BRK66_PCT / `RPD_PCT_FULL);
	localparam rpd_tmr_t B20_60_TK = 12'(`RPD_MS2TK(`RPD_PERIOD20_MS)
		* `RPD_BRK60_PCT / `RPD_PCT_FULL);
	localparam rpd_tmr_t B20_66_TK = 12'(`RPD_MS2TK(`RPD_PERIOD20_MS)
		* `RPD_BRK66_PCT / `RPD_PCT_FULL);
	localparam rpd_tmr_t F10_TK = 12'(`RPD_MS2TK(`RPD_PERIOD10_MS)
		/ `RPD_FAST_DIV);
	localparam rpd_tmr_t F20_TK = 12'(`RPD_MS2TK(`RPD_PERIOD20_MS)
		/ `RPD_FAST_DIV);
	localparam rpd_tmr_t PDP10_TK = 12'(`RPD_MS2TK(`RPD_PDP10_MS));
	localparam rpd_tmr_t PDP20_TK = 12'(`RPD_MS2TK(`RPD_PDP20_MS));
	localparam rpd_tmr_t IDT10_TK = 12'(`RPD_MS2TK(`RPD_IDT10_MS));
	localparam rpd_tmr_t IDT20_TK = 12'(`RPD_MS2TK(`RPD_IDT20_MS));
	localparam rpd_tmr_t TAIL_TK = 12'(`RPD_MS2TK(`RPD_MUTE_TAIL_MS));
	localparam rpd_tmr_t HOOK_TK = 12'(`RPD_MS2TK(`RPD_ONHOOK_MS));
	localparam logic [1:0] TONE10_HALF = 2'(`RPD_TICK_KHZ
		* `RPD_HZ_PER_KHZ / (`RPD_TONE_EDGES * `RPD_TONE10_HZ));
	localparam logic [1:0] TONE20_HALF = 2'(`RPD_TICK_KHZ
		* `RPD_HZ_PER_KHZ / (`RPD_TONE_EDGES * `RPD_TONE20_HZ));
	localparam logic [13:0] DIV_LAST = 14'(TICK_DIV - 1);
	localparam rpd_count_t DEPTH = 5'(`RPD_MEM_DEPTH);

	logic rst_meta_q;
	logic rst_n;
	logic hook_q;
	logic off_edge;
	logic on_hook;
	logic run;
	logic run_q;
	logic [13:0] div_q;
	logic tick;
	rpd_tmr_t hook_tmr_q;
	logic hook_long_q;
	logic first_q;
	logic tone_q;
	logic [1:0] tone_cnt_q;
	rpd_digit_t mem_q [`RPD_MEM_DEPTH];
	rpd_count_t len_q;
	rpd_count_t rd_q;
	rpd_state_t state_q;
	rpd_tmr_t tmr_q;
	rpd_digit_t pcnt_q;
	logic pulse_oe_q;
	logic mute_oe_q;
	logic is_fn;
	logic replay_go;
	logic store_go;
	rpd_digit_t pulses;
	logic pending;
	logic tmr_end;
	rpd_tmr_t brk_tk, make_tk, pdp_tk, idt_tk, per_tk;
	rpd_key_if kif ();

	// Reset release through two stages, assertion stays asynchronous
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// A floating hook pin reads high outside, so it lands on-hook
	assign on_hook = HOOK_TEST_SELECT;
	assign off_edge = hook_q && !on_hook;

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			hook_q <= 1'b1;
		end else begin
			hook_q <= on_hook;
		end
	end

	// Gated oscillator: only runs while something needs time
	assign run = kif.sensed || kif.busy || (state_q != RPD_IDLE)
		|| (on_hook && !hook_long_q);
	assign tick = run_q && (div_q == DIV_LAST);

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			div_q <= 14'h0;
		end else begin
			run_q <= run;
			if (!run_q || tick) begin
				div_q <= 14'h0;
			end else begin
				div_q <= div_q + 14'h1;
			end
		end
	end

	assign kif.tick = tick;
	assign kif.on_hook = on_hook;

	rpd_keyscan u_keyscan (
		.clk(MCLK),
		.rst_n(rst_n),
		.row_i(ROW_I),
		.row_o(ROW_O),
		.row_oe(ROW_OE),
		.col_i(COL_I),
		.col_o(COL_O),
		.col_oe(COL_OE),
		.kif(kif.scan)
	);

	// Time spent on-hook decides whether the next call may redial
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			hook_tmr_q <= 12'h0;
			hook_long_q <= 1'b0;
		end else if (!on_hook) begin
			hook_tmr_q <= 12'h0;
			hook_long_q <= 1'b0;
		end else if (tick && !hook_long_q) begin
			hook_tmr_q <= hook_tmr_q + 12'h1;
			if (hook_tmr_q + 12'h1 >= HOOK_TK) hook_long_q <= 1'b1;
		end
	end

	assign is_fn = (kif.code == `RPD_KEY_STAR)
		|| (kif.code == `RPD_KEY_HASH);
	assign pulses = (kif.code == `RPD_KEY_ZERO) ? `RPD_ZERO_PULSES
		: kif.code + 4'h1;
	assign replay_go = kif.accept && !on_hook && first_q && is_fn
		&& (len_q != 5'h0);
	assign store_go = kif.accept && !on_hook && !is_fn
		&& (first_q || len_q < DEPTH);

	// First key after a long on-hook either redials or starts afresh
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			first_q <= 1'b1;
		end else if (off_edge) begin
			first_q <= hook_long_q;
		end else if (replay_go || store_go) begin
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			len_q <= 5'h0;
		end else if (store_go) begin
			len_q <= first_q ? 5'h1 : len_q + 5'h1;
		end
	end

	// No reset on the digit store: contents only matter below len_q
	always_ff @(posedge MCLK) begin
		if (store_go) begin
			mem_q[first_q ? 5'h0 : len_q] <= pulses;
		end
	end

	// On-hook while dialing squeezes the rest out at a hundredfold rate
	always_comb begin
		per_tk = DIAL_RATE_SELECT ? PER20_TK : PER10_TK;
		pdp_tk = DIAL_RATE_SELECT ? PDP20_TK : PDP10_TK;
		idt_tk = DIAL_RATE_SELECT ? IDT20_TK : IDT10_TK;
		if (DIAL_RATE_SELECT) begin
			brk_tk = BREAK_RATIO_SELECT ? B20_66_TK : B20_60_TK;
		end else begin
			brk_tk = BREAK_RATIO_SELECT ? B10_66_TK : B10_60_TK;
		end
		if (on_hook) begin
			per_tk = DIAL_RATE_SELECT ? F20_TK : F10_TK;
			brk_tk = per_tk / 12'(`RPD_FAST_DUTY_DIV);
			pdp_tk = pdp_tk / 12'(`RPD_FAST_DIV);
			idt_tk = idt_tk / 12'(`RPD_FAST_DIV);
		end
		make_tk = per_tk - brk_tk;
	end

	assign pending = (rd_q != len_q);
	assign tmr_end = tick && (tmr_q <= 12'h1);

	// Outpulsing sequencer; each state but RPD_IDLE lasts tmr_q ticks, except that RPD_TAIL ends at once when a digit is pending
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= RPD_IDLE;
			tmr_q <= 12'h0;
			pcnt_q <= 4'h0;
			rd_q <= 5'h0;
		end else if (off_edge) begin
			state_q <= RPD_IDLE;
			tmr_q <= 12'h0;
			pcnt_q <= 4'h0;
			rd_q <= len_q;
		end else if (replay_go || (store_go && first_q)) begin
			state_q <= RPD_PAUSE;
			tmr_q <= pdp_tk;
			rd_q <= 5'h0;
		end else begin
			if (tick && tmr_q > 12'h1) tmr_q <= tmr_q - 12'h1;
			case (state_q)
				RPD_IDLE: begin
					if (pending && !on_hook) begin
						state_q <= RPD_PAUSE;
						tmr_q <= pdp_tk;
					end
				end
				RPD_PAUSE: begin
					if (tmr_end) begin
						state_q <= RPD_BREAK;
						tmr_q <= brk_tk;
						pcnt_q <= mem_q[rd_q];
					end
				end
				RPD_BREAK: begin
					if (tmr_end) begin
						state_q <= RPD_MAKE;
						tmr_q <= make_tk;
					end
				end
				RPD_MAKE: begin
					if (tmr_end) begin
						if (pcnt_q > 4'h1) begin
							pcnt_q <= pcnt_q - 4'h1;
							state_q <= RPD_BREAK;
							tmr_q <= brk_tk;
						end else begin
							rd_q <= rd_q + 5'h1;
							if (rd_q + 5'h1 != len_q) begin
								state_q <= RPD_PAUSE;
								tmr_q <= idt_tk;
							end else begin
								state_q <= RPD_TAIL;
								tmr_q <= TAIL_TK;
							end
						end
					end
				end
				RPD_TAIL: begin
					if (pending) begin
						state_q <= RPD_PAUSE;
						tmr_q <= idt_tk;
					end else if (tmr_end) begin
						state_q <= RPD_IDLE;
					end
				end
				default: begin
					state_q <= RPD_IDLE;
				end
			endcase
		end
	end

	// Mute also held across on-hook so going off-hook releases it
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			pulse_oe_q <= 1'b0;
			mute_oe_q <= 1'b0;
		end else begin
			pulse_oe_q <= (state_q == RPD_BREAK);
			mute_oe_q <= (state_q != RPD_IDLE) || on_hook;
		end
	end

	// Tone follows the debounced key, toggled from the tick
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			tone_q <= 1'b0;
			tone_cnt_q <= 2'h0;
		end else if (!kif.held || on_hook) begin
			tone_q <= 1'b0;
			tone_cnt_q <= 2'h0;
		end else if (tick) begin
			if (tone_cnt_q + 2'h1 >= (DIAL_RATE_SELECT ? TONE20_HALF
				: TONE10_HALF)) begin
				tone_q <= !tone_q;
				tone_cnt_q <= 2'h0;
			end else begin
				tone_cnt_q <= tone_cnt_q + 2'h1;
			end
		end
	end

	assign PULSE_OUT_N_O = 1'b0;
	assign PULSE_OUT_N_OE = pulse_oe_q;
	assign MUTE_OUT_N_O = 1'b0;
	assign MUTE_OUT_N_OE = mute_oe_q;
	assign TONE_FEEDBACK_OUT = tone_q;
	assign CLOCK_RUN = run_q;
	assign STORED_DIGITS = len_q;
endmodule : rpd_dialer

// ==== verification/rpd_keypad_model.sv ====
`timescale 1ns/1ns
module rpd_keypad_model (
	input wire logic [3:0] row_o,
	input wire logic [3:0] row_oe,
	input wire logic [2:0] col_o,
	input wire logic [2:0] col_oe,
	input wire logic press,
	input wire logic gnd,
	input wire logic [1:0] krow,
	input wire logic [1:0] kcol,
	output logic [3:0] row_i,
	output logic [2:0] col_i
);
	logic [3:0] rl;
	logic [2:0] cl;
	always_comb begin
		// Undriven lines float up through the pull-ups
		rl = row_o | ~row_oe;
		cl = col_o | ~col_oe;
		row_i = rl;
		col_i = cl;
		if (press) begin
			row_i[krow] = !gnd && rl[krow] && cl[kcol];
			col_i[kcol] = row_i[krow];
		end
	end
endmodule : rpd_keypad_model

// ==== verification/rpd_dialer_chk.sv ====
`timescale 1ns/1ns
module rpd_dialer_chk #(
	parameter int unsigned TICK_DIV = 4
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic HOOK_TEST_SELECT,
	input wire logic DIAL_RATE_SELECT,
	input wire logic BREAK_RATIO_SELECT,
	input wire logic [3:0] ROW_I,
	input wire logic [3:0] ROW_O,
	input wire logic [3:0] ROW_OE,
	input wire logic [2:0] COL_I,
	input wire logic [2:0] COL_O,
	input wire logic [2:0] COL_OE,
	input wire logic PULSE_OUT_N_O,
	input wire logic PULSE_OUT_N_OE,
	input wire logic MUTE_OUT_N_O,
	input wire logic MUTE_OUT_N_OE,
	input wire logic TONE_FEEDBACK_OUT,
	input wire logic CLOCK_RUN,
	input wire rpd_pkg::rpd_count_t STORED_DIGITS
);
	import rpd_pkg::*;
	int unsigned brk_len, idle_len, tg_len, off_len, brk_exp, half, tail;
	logic brk_any, brk_all, hook_q, tone_q;
	always_comb brk_exp = TICK_DIV * (DIAL_RATE_SELECT ?
		(BREAK_RATIO_SELECT ? 132 : 120) : (BREAK_RATIO_SELECT ? 264 : 240));
	always_comb half = TICK_DIV * (DIAL_RATE_SELECT ? 1 : 2);
	always_comb tail = TICK_DIV * (DIAL_RATE_SELECT ? 220 : 420) - brk_exp;
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			brk_len <= 0;
			idle_len <= 0;
			tg_len <= 0;
			off_len <= 0;
			brk_any <= 1'b0;
			brk_all <= 1'b0;
			hook_q <= 1'b1;
			tone_q <= 1'b0;
		end else begin
			brk_len <= PULSE_OUT_N_OE ? brk_len + 1 : 0;
			idle_len <= PULSE_OUT_N_OE ? 0 : idle_len + 1;
			tg_len <= (TONE_FEEDBACK_OUT != tone_q) ? 1 : tg_len + 1;
			off_len <= HOOK_TEST_SELECT ? 0 : off_len + 1;
			// Hook seen just before a break counts, the break output lags inside by a register
			brk_any <= HOOK_TEST_SELECT | (PULSE_OUT_N_OE & brk_any);
			brk_all <= HOOK_TEST_SELECT & (PULSE_OUT_N_OE ? brk_all : hook_q);
			hook_q <= HOOK_TEST_SELECT;
			tone_q <= TONE_FEEDBACK_OUT;
		end
	end
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	sequence s_stored;
		$changed(STORED_DIGITS) && STORED_DIGITS != 5'h0 && off_len > 16;
	endsequence
	sequence s_muting;
		##[0:3] MUTE_OUT_N_OE;
	endsequence
	AST_ODRAIN_LOW: assert property (!PULSE_OUT_N_O && !MUTE_OUT_N_O)
		else $error("open drain data not low");
	AST_BREAK_MUTED: assert property (
		PULSE_OUT_N_OE |-> MUTE_OUT_N_OE && CLOCK_RUN)
		else $error("break outside mute");
	AST_HOOK_KEYPAD: assert property (HOOK_TEST_SELECT [*4] |->
		{ROW_OE, ROW_O, COL_OE, COL_O} == 14'h3fff)
		else $error("keypad not high on hook");
	AST_HOOK_MUTE: assert property (
		HOOK_TEST_SELECT [*8] |-> MUTE_OUT_N_OE)
		else $error("mute not held on hook");
	AST_BREAK_LEN: assert property ($fell(PULSE_OUT_N_OE) && !brk_any |->
		brk_len inside {[brk_exp - 1:brk_exp + 1]})
		else $error("break length wrong");
	AST_FAST_BREAK: assert property ($fell(PULSE_OUT_N_OE) && brk_all |->
		brk_len inside {[half - 1:half + 1]})
		else $error("fast break length wrong");
	AST_MUTE_TAIL: assert property ($fell(MUTE_OUT_N_OE) && off_len > 16 |->
		idle_len inside {[tail - 2:tail + 2]})
		else $error("mute tail wrong");
	AST_TONE_HALF: assert property (
		$rose(TONE_FEEDBACK_OUT) && tg_len < 8 * TICK_DIV |->
		tg_len inside {[half - 1:half + 1]})
		else $error("tone period wrong");
	AST_STORE_MUTE: assert property (s_stored |-> s_muting)
		else $error("no mute after store");
	AST_DIGIT_CAP: assert property (STORED_DIGITS <= 5'd17)
		else $error("digit count too large");
endmodule : rpd_dialer_chk
bind rpd_dialer rpd_dialer_chk #(.TICK_DIV(TICK_DIV)) u_chk (.MCLK(MCLK),
	.RST_N(RST_N), .HOOK_TEST_SELECT(HOOK_TEST_SELECT),
	.DIAL_RATE_SELECT(DIAL_RATE_SELECT), .ROW_I(ROW_I),
	.BREAK_RATIO_SELECT(BREAK_RATIO_SELECT), .ROW_O(ROW_O),
	.ROW_OE(ROW_OE), .COL_I(COL_I), .COL_O(COL_O), .COL_OE(COL_OE),
	.PULSE_OUT_N_O(PULSE_OUT_N_O), .PULSE_OUT_N_OE(PULSE_OUT_N_OE),
	.MUTE_OUT_N_O(MUTE_OUT_N_O), .MUTE_OUT_N_OE(MUTE_OUT_N_OE),
	.TONE_FEEDBACK_OUT(TONE_FEEDBACK_OUT), .CLOCK_RUN(CLOCK_RUN),
	.STORED_DIGITS(STORED_DIGITS));

// ==== verification/rpd_dialer_tb.sv ====
`timescale 1ns/1ns
module rpd_dialer_tb;
	import rpd_pkg::*;
	localparam int DIV = 4;
	localparam int MS = 4 * DIV;
	logic mclk, rst_n, hook, rate, ratio, press, gnd, pq, mq, tq;
	logic pulse_o, pulse_oe, mute_o, mute_oe, tone, clk_run;
	logic [1:0] krow, kcol;
	logic [3:0] row_i, row_o, row_oe;
	logic [2:0] col_i, col_o, col_oe;
	rpd_count_t stored;
	int num_errors, tests_run, cyc, brk_n, tone_n, t_mute, t_brk;
	rpd_dialer #(.TICK_DIV(DIV)) u_dut (.MCLK(mclk), .RST_N(rst_n),
		.HOOK_TEST_SELECT(hook), .DIAL_RATE_SELECT(rate),
		.BREAK_RATIO_SELECT(ratio), .ROW_I(row_i), .ROW_O(row_o),
		.ROW_OE(row_oe), .COL_I(col_i), .COL_O(col_o), .COL_OE(col_oe),
		.PULSE_OUT_N_O(pulse_o), .PULSE_OUT_N_OE(pulse_oe),
		.MUTE_OUT_N_O(mute_o), .MUTE_OUT_N_OE(mute_oe),
		.TONE_FEEDBACK_OUT(tone), .CLOCK_RUN(clk_run), .STORED_DIGITS(stored));
	rpd_keypad_model u_pad (.row_o(row_o), .row_oe(row_oe), .col_o(col_o),
		.col_oe(col_oe), .press(press), .gnd(gnd), .krow(krow), .kcol(kcol),
		.row_i(row_i), .col_i(col_i));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	always @(posedge mclk) begin
		if (mute_oe === 1'b1 && mq !== 1'b1)
			t_mute = cyc;
		if (pulse_oe === 1'b1 && pq !== 1'b1) begin
			t_brk = brk_n == 0 ? cyc : t_brk;
			brk_n++;
		end
		if (tone === 1'b1 && tq !== 1'b1)
			tone_n++;
		{pq, mq, tq} = {pulse_oe, mute_oe, tone};
		cyc++;
		if (cyc == 110000) begin
			num_errors++;
			results();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic near(input int a, input int b);
		check(16'(a > b - 6 && a < b + 6), 16'h1);
	endtask : near
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic key(input int r, input int c, input int ms);
		krow = r[1:0];
		kcol = c[1:0];
		press = 1'b1;
		step(ms * MS);
		press = 1'b0;
		// Two idle scans so the next press starts as a fresh key
		step(2 * MS);
	endtask : key
	// Dialing over once the mute lets go
	task automatic settle();
		int n;
		for (n = 0; n < 60000 && mute_oe !== 1'b0; n++)
			step(1);
	endtask : settle
	task automatic t_idle();
		check({clk_run, pulse_oe, mute_oe, tone}, 4'h0);
		check({col_oe, col_o, stored}, {3'h7, 3'h0, 5'h0});
		$display("idle done");
	endtask : t_idle
	task automatic t_ten();
		brk_n = 0;
		key(0, 1, 50);
		check(stored, 5'h1);
		settle();
		check(16'(brk_n), 16'h2);
		near(t_brk - t_mute, 3600 * DIV);
		step(8);
		check(clk_run, 1'b0);
		$display("ten pps done");
	endtask : t_ten
	task automatic t_zero();
		rate = 1'b1;
		ratio = 1'b1;
		gnd = 1'b1;
		brk_n = 0;
		key(3, 1, 50);
		gnd = 1'b0;
		check(stored, 5'h2);
		settle();
		check(16'(brk_n), 16'ha);
		near(t_brk - t_mute, 1800 * DIV);
		$display("zero done");
	endtask : t_zero
	task automatic t_short();
		tone_n = 0;
		key(1, 1, 20);
		check(16'(tone_n > 0), 16'h1);
		settle();
		check(stored, 5'h2);
		$display("short press done");
	endtask : t_short
	task automatic t_fast();
		int n;
		ratio = 1'b0;
		brk_n = 0;
		key(0, 2, 50);
		for (n = 0; n < 9000 && brk_n == 0; n++)
			step(1);
		hook = 1'b1;
		// Keys typed on hook must not reach memory
		key(1, 0, 50);
		step(1050 * DIV);
		check(16'(brk_n), 16'h3);
		check(stored, 5'h3);
		check({row_oe, row_o, col_oe, col_o, mute_oe, clk_run}, 16'hfffe);
		hook = 1'b0;
		step(4);
		check(mute_oe, 1'b0);
		$display("fast finish done");
	endtask : t_fast
	task automatic t_redial();
		brk_n = 0;
		key(3, 0, 50);
		settle();
		check(16'(brk_n), 16'hf);
		check(stored, 5'h3);
		$display("redial done");
	endtask : t_redial
	task automatic t_clear();
		int n;
		hook = 1'b1;
		step(1250 * DIV);
		hook = 1'b0;
		step(4);
		key(1, 1, 50);
		check(stored, 5'h1);
		// Fill the store; the eighteenth key must be dropped
		for (n = 0; n < 17; n++)
			key(0, 0, 42);
		check(stored, 5'h11);
		$display("clear done");
	endtask : t_clear
	initial begin
		{rst_n, hook, rate, ratio, press, gnd, krow, kcol} = 10'h0;
		step(3);
		rst_n = 1'b1;
		step(3);
		t_idle();
		t_ten();
		t_zero();
		t_short();
		t_fast();
		t_redial();
		t_clear();
		results();
	end
endmodule : rpd_dialer_tb
